// *** hw/acs_sequencer.sv ***
// Conversion sequencer with APB register file and result formatting.
// Assumes an analog core that samples while anaSample is high, converts
// while anaConvert is high and still presents its code one clock after anaConvert falls.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic startEvt, // Start event, asynchronous
    output logic resultReadyEvt, // Result ready event pulse
    output logic anaClkAdc, // Converter clock
    output logic anaSample, // Sample-and-hold active
    output logic anaConvert, // Conversion active
    input wire logic [11:0] anaData, // Core code at end of conversion
    input wire logic anaHigh, // Input above reference
    input wire logic anaLow // Input below negative limit
);
    // ==========================================================
    // Registers
    logic [4:0] ctrlFirst;
    logic [2:0] sampleCountField;
    logic [7:0] prescField;
    logic [7:0] initDelayField;
    logic [3:0] samplingDelayField;
    logic [7:0] sampleLengthField;
    logic startEventEnable;
    logic resultReadyFlag;
    logic [15:0] conversionResult;

    acs_state_e state;
    logic [1:0] stepCnt;
    logic [7:0] presCnt;
    logic [9:0] phaseCnt;
    logic [7:0] sampleIdx;
    logic initDone;
    logic enablePrev;
    acs_acc_t acc;
    logic evtSync;
    logic evtPrev;

    logic enable, freeRun, left_adjust_bit, diffMode, res10;
    logic wrAcc, rdSetup, addrOk, startWr, clearWr, trigger;
    logic halfTick, phaseEnd, busy, done, lastSample;
    logic [9:0] sampTarget;
    logic [9:0] initTarget;
    logic [7:0] sampleTotal;
    logic signed [12:0] sampleVal;
    logic [11:0] satCode;
    logic [15:0] fmtResult;

    assign enable = ctrlFirst[`ACS_BIT_ENABLE];
    assign freeRun = ctrlFirst[`ACS_BIT_FREERUN];
    assign left_adjust_bit = ctrlFirst[`ACS_BIT_LEFT_ADJUST_BIT];
    assign diffMode = ctrlFirst[`ACS_BIT_DIFF];
    assign res10 = ctrlFirst[`ACS_BIT_RES10];

    // ==========================================================
    // APB slave
    always_comb begin
        unique case (paddr)
            `ACS_OFS_CTRL_FIRST, `ACS_OFS_CTRL_SECOND, `ACS_OFS_CTRL_THIRD,
            `ACS_OFS_CTRL_FOURTH, `ACS_OFS_SAMP_CTRL, `ACS_OFS_COMMAND,
            `ACS_OFS_EVENT_CTRL, `ACS_OFS_FLAGS,
            `ACS_OFS_RESULT: addrOk = 1'b1;
            default: addrOk = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign wrAcc = psel && penable && pwrite && addrOk && ce;
    assign rdSetup = psel && !penable && !pwrite;
    assign startWr = wrAcc && paddr == `ACS_OFS_COMMAND
        && pwdata[`ACS_BIT_START];
    assign clearWr = wrAcc && paddr == `ACS_OFS_FLAGS
        && pwdata[`ACS_BIT_RESULT_READY_FLAG];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrlFirst <= `ACS_RST_CTRL;
            sampleCountField <= `ACS_RST_SAMPLE_COUNT_FIELD;
            prescField <= `ACS_RST_BYTE;
            initDelayField <= `ACS_RST_BYTE;
            samplingDelayField <= `ACS_RST_NIBBLE;
            sampleLengthField <= `ACS_RST_BYTE;
            startEventEnable <= 1'b0;
        end else if (wrAcc) begin
            unique case (paddr)
                `ACS_OFS_CTRL_FIRST: ctrlFirst <= pwdata[4:0];
                `ACS_OFS_CTRL_SECOND:
                    sampleCountField <= pwdata[`ACS_FLD_SAMPLE_COUNT_FIELD];
                `ACS_OFS_CTRL_THIRD: prescField <= pwdata[`ACS_FLD_PRESC];
                `ACS_OFS_CTRL_FOURTH: begin
                    initDelayField <= pwdata[`ACS_FLD_INITIALIZATION_DELAY_FIELD];
                    samplingDelayField <= pwdata[`ACS_FLD_SAMPLING_DELAY_FIELD];
                end
                `ACS_OFS_SAMP_CTRL:
                    sampleLengthField <= pwdata[`ACS_FLD_SAMPLE_LENGTH_FIELD];
                `ACS_OFS_EVENT_CTRL:
                    startEventEnable <= pwdata[`ACS_BIT_STARTEI];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (ce && rdSetup) begin
            unique case (paddr)
                `ACS_OFS_CTRL_FIRST: prdata <= {27'h0, ctrlFirst};
                `ACS_OFS_CTRL_SECOND: prdata <= {29'h0, sampleCountField};
                `ACS_OFS_CTRL_THIRD: prdata <= {24'h0, prescField};
                `ACS_OFS_CTRL_FOURTH:
                    prdata <= {20'h0, samplingDelayField, initDelayField};
                `ACS_OFS_SAMP_CTRL: prdata <= {24'h0, sampleLengthField};
                `ACS_OFS_COMMAND: prdata <= {31'h0, busy};
                `ACS_OFS_EVENT_CTRL: prdata <= {31'h0, startEventEnable};
                `ACS_OFS_FLAGS: prdata <= {31'h0, resultReadyFlag};
                `ACS_OFS_RESULT: prdata <= {16'h0, conversionResult};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Start event edge detect
    acs_sync2 u_evt_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .din(startEvt),
        .dout(evtSync)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            evtPrev <= 1'b0;
        end else if (ce) begin
            evtPrev <= evtSync;
        end
    end

    assign trigger = enable && (startWr
        || (startEventEnable && evtSync && !evtPrev));

    // ==========================================================
    // Converter clock prescaler and phase counter
    assign busy = state != ACS_IDLE;
    assign halfTick = presCnt == prescField;
    // sample phase stretched by delay and length fields
    assign sampTarget = (`ACS_SAMPLE_BASE + 10'(samplingDelayField)
        + 10'(sampleLengthField)) << 1;
    assign initTarget = {1'b0, initDelayField, 1'b0};
    assign sampleTotal = 8'h01 << sampleCountField;
    assign lastSample = sampleIdx == sampleTotal - 8'h01;
    assign phaseEnd = halfTick && phaseCnt == (state == ACS_SAMPLE
        ? sampTarget : state == ACS_CONV ? `ACS_CONV_HALVES
        : initTarget) - 10'h001;
    assign done = state == ACS_FMT && stepCnt == `ACS_FMT_CYCLES - 2'h1
        && lastSample;

    // prescaler held in reset outside a timed phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presCnt <= 8'h00;
            phaseCnt <= 10'h000;
            anaClkAdc <= 1'b0;
        end else if (ce) begin
            if (state == ACS_SAMPLE || state == ACS_CONV
                || state == ACS_INIT) begin
                presCnt <= halfTick ? 8'h00 : presCnt + 8'h01;
                if (halfTick) begin
                    phaseCnt <= phaseEnd ? 10'h000 : phaseCnt + 10'h001;
                    anaClkAdc <= !anaClkAdc;
                end
            end else begin
                presCnt <= 8'h00;
                phaseCnt <= 10'h000;
                anaClkAdc <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ACS_IDLE;
            stepCnt <= 2'h0;
            sampleIdx <= 8'h00;
        end else if (ce) begin
            if (!enable) begin
                state <= ACS_IDLE;
            end else begin
                unique case (state)
                    ACS_IDLE: if (trigger) begin
                        state <= ACS_START;
                        stepCnt <= 2'h0;
                    end
                    ACS_START: begin
                        stepCnt <= stepCnt + 2'h1;
                        sampleIdx <= 8'h00;
                        if (stepCnt == `ACS_START_CYCLES - 2'h1) begin
                            stepCnt <= 2'h0;
                            state <= (initDone || initTarget == 10'h000)
                                ? ACS_SAMPLE : ACS_INIT;
                        end
                    end
                    ACS_INIT: if (phaseEnd) state <= ACS_SAMPLE;
                    ACS_SAMPLE: if (phaseEnd) state <= ACS_CONV;
                    ACS_CONV: if (phaseEnd) state <= ACS_FMT;
                    ACS_FMT: begin
                        stepCnt <= stepCnt + 2'h1;
                        if (stepCnt == `ACS_FMT_CYCLES - 2'h1) begin
                            stepCnt <= 2'h0;
                            sampleIdx <= sampleIdx + 8'h01;
                            // loop until every sample is done
                            if (!lastSample) begin
                                state <= ACS_SAMPLE;
                            end else if (freeRun) begin
                                state <= ACS_START;
                            end else begin
                                state <= ACS_IDLE;
                            end
                        end
                    end
                    default: state <= ACS_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            initDone <= 1'b0;
            enablePrev <= 1'b0;
        end else if (ce) begin
            enablePrev <= enable;
            if (enable && !enablePrev) begin
                initDone <= 1'b0;
            end else if (state == ACS_INIT && phaseEnd) begin
                initDone <= 1'b1;
            end
        end
    end

    assign anaSample = state == ACS_SAMPLE;
    assign anaConvert = state == ACS_CONV;

    // ==========================================================
    // Sample capture and accumulation
    always_comb begin
        satCode = anaData;
        if (anaHigh) begin
            satCode = diffMode ? `ACS_SAT_DF_HI : `ACS_SAT_SE_HI;
        end else if (anaLow) begin
            satCode = diffMode ? `ACS_SAT_DF_LO : `ACS_SAT_SE_LO;
        end
        sampleVal = diffMode ? {satCode[11], satCode}
            : {1'b0, satCode};
        if (res10) begin
            sampleVal = sampleVal >>> `ACS_TEN_BIT_DROP;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc <= 20'sh00000;
        end else if (ce) begin
            // sum cleared at each start, kept clear while idle
            if (state == ACS_START || state == ACS_IDLE) begin
                acc <= 20'sh00000;
            end else if (state == ACS_FMT && stepCnt == 2'h0) begin
                acc <= acc + 20'(sampleVal);
            end
        end
    end

    acs_formatter u_fmt (
        .clk_sys(clk_sys),
        .rst(rst),
        .acc(acc),
        .sampLog(sampleCountField),
        .res10(res10),
        .diffMode(diffMode),
        .left_adjust_bit(left_adjust_bit),
        .result(fmtResult)
    );

    // result and flag change on done; busy drops then too unless continuous mode restarts
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conversionResult <= `ACS_RST_RESULT;
            resultReadyFlag <= 1'b0;
            resultReadyEvt <= 1'b0;
        end else if (ce) begin
            resultReadyEvt <= done;
            if (done) begin
                conversionResult <= fmtResult;
            end
            // flag set wins over a clear
            if (done) begin
                resultReadyFlag <= 1'b1;
            end else if (clearWr) begin
                resultReadyFlag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_fmt_end;
        ce && done;
    endsequence

    property p_start_delay;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ACS_IDLE && trigger) |=> state == ACS_START;
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("conversion did not start one clock after trigger");

    property p_conv_len;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ACS_CONV && phaseEnd)
            |-> phaseCnt == `ACS_CONV_HALVES - 10'h001;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion phase length wrong");

    property p_samp_len;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ACS_SAMPLE && halfTick && phaseCnt ==
            sampTarget - 10'h001) |=> state == ACS_CONV || !ce;
    endproperty
    a_samp_len: assert property (p_samp_len)
        else $error("sampling phase length wrong");

    property p_done_same;
        @(posedge clk_sys) disable iff (rst)
        s_fmt_end |=> resultReadyFlag && resultReadyEvt
            && conversionResult == $past(fmtResult)
            && (state != ACS_SAMPLE);
    endproperty
    a_done_same: assert property (p_done_same)
        else $error("result, flag and busy not updated together");

    property p_count;
        @(posedge clk_sys) disable iff (rst)
        s_fmt_end |-> sampleIdx == sampleTotal - 8'h01;
    endproperty
    a_count: assert property (p_count)
        else $error("wrong number of samples accumulated");

    property p_freerun;
        @(posedge clk_sys) disable iff (rst)
        (s_fmt_end and (freeRun && enable)) |=> state == ACS_START;
    endproperty
    a_freerun: assert property (p_freerun)
        else $error("continuous mode did not restart");

    property p_busy_hold;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ACS_FMT && !lastSample && enable)
            |=> busy [*2];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped between samples");

    property p_acc_clear;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ACS_START) |=> acc == 20'sh00000;
    endproperty
    a_acc_clear: assert property (p_acc_clear)
        else $error("sum not cleared at start");

    property p_init;
        @(posedge clk_sys) disable iff (rst)
        (ce && state == ACS_SAMPLE)
            |-> initDone || initTarget == 10'h000 || enable == 1'b0
            || $past(state) != ACS_START;
    endproperty
    a_init: assert property (p_init)
        else $error("sampling began inside initialization delay");
endmodule
`default_nettype wire

// *** hw/acs_regs.svh ***
// Register map, field positions and timing counts of the conversion
// sequencer. Assumes inclusion by the sequencer and formatter modules.
//
// Overview of operation
// - Single conversion: 2+13.5 converter clocks plus 4 system clocks.
// - Samples per trigger come from the sample-count field.
// - Busy command bit stays set across every sample until formatted.
// - n samples: 2 clocks once, then per sample 15.5 ADC plus 2 clocks.
// - Continuous mode restarts a conversion right after each one ends.
// - Continuous mode sets ready flag and pulses event every conversion.
// - Continuous mode restarts also accumulate the configured sample count.
// - Sampling lasts 2 plus delay field plus length field ADC clocks.
// - Each sample adds delay and length fields to its 15.5 ADC clocks.
// - After enable, sampling waits the programmed initialization delay.
// - Single-ended results unsigned: 0..4095 at 12 bit, 0..1023 at 10.
// - Differential results two's complement, sign extended to 16 bits when right adjusted.
// - Right adjust by default; left adjust puts MSbs in high byte.
// - Single-ended 12-bit saturates to 0xFFF above and 0x000 below.
// - Differential 12-bit saturates to 2047 and -2048.
// - Above 16 samples, sum LSbs are dropped to fit 16 bits.
// - Sums of 1..8 samples are 12..15 bits at 12 bit, 10..13 at 10 bit, zero-filled, except sign-filled when differential and right adjusted.
// - Accumulator clears to zero when a new conversion starts.
// - Start bit or trigger edge starts after one clock; prescaler idle.
// - 16 samples store full sum; 32..128 store truncated sum at 12 bit, only 128 at 10 bit.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================================
// Register offsets
`define ACS_OFS_CTRL_FIRST 8'h00
`define ACS_OFS_CTRL_SECOND 8'h04
`define ACS_OFS_CTRL_THIRD 8'h08
`define ACS_OFS_CTRL_FOURTH 8'h0C
`define ACS_OFS_SAMP_CTRL 8'h10
`define ACS_OFS_COMMAND 8'h14
`define ACS_OFS_EVENT_CTRL 8'h18
`define ACS_OFS_FLAGS 8'h1C
`define ACS_OFS_RESULT 8'h20

// ==========================================================
// Field positions
`define ACS_BIT_ENABLE 0
`define ACS_BIT_FREERUN 1
`define ACS_BIT_LEFT_ADJUST_BIT 2
`define ACS_BIT_DIFF 3
`define ACS_BIT_RES10 4
`define ACS_BIT_START 0
`define ACS_BIT_STARTEI 0
`define ACS_BIT_RESULT_READY_FLAG 0
`define ACS_FLD_SAMPLE_COUNT_FIELD 2:0
`define ACS_FLD_PRESC 7:0
`define ACS_FLD_INITIALIZATION_DELAY_FIELD 7:0
`define ACS_FLD_SAMPLING_DELAY_FIELD 11:8
`define ACS_FLD_SAMPLE_LENGTH_FIELD 7:0

// ==========================================================
// Reset values
`define ACS_RST_CTRL 5'h00
`define ACS_RST_SAMPLE_COUNT_FIELD 3'h0
`define ACS_RST_BYTE 8'h00
`define ACS_RST_NIBBLE 4'h0
`define ACS_RST_RESULT 16'h0000

// ==========================================================
// Timing counts (system clocks, converter clocks or half periods), full-sum sample log
`define ACS_START_CYCLES 2'h2
`define ACS_FMT_CYCLES 2'h2
`define ACS_SAMPLE_BASE 10'h002
`define ACS_CONV_HALVES 10'h01B
`define ACS_FULL_SUM_LOG 3'h4

// ==========================================================
// Result format
`define ACS_RES_W 16
`define ACS_SAT_SE_HI 12'hFFF
`define ACS_SAT_SE_LO 12'h000
`define ACS_SAT_DF_HI 12'h7FF
`define ACS_SAT_DF_LO 12'h800
`define ACS_CODE_W12 5'h0C
`define ACS_CODE_W10 5'h0A
`define ACS_TEN_BIT_DROP 2

`endif

// *** hw/acs_pkg.sv ***
// Types shared by the conversion sequencer modules.
// Assumes the register header is on the include path.
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_IDLE = 3'h0,
        ACS_START = 3'h1,
        ACS_INIT = 3'h3,
        ACS_SAMPLE = 3'h2,
        ACS_CONV = 3'h6,
        ACS_FMT = 3'h7
    } acs_state_e;
    typedef logic signed [19:0] acs_acc_t;
endpackage

// *** hw/acs_sync2.sv ***
// Two-stage synchroniser for one asynchronous level.
// Assumes clock enable gating like the rest of the block.
`timescale 1ns/1ps
`default_nettype none
module acs_sync2 (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic din, // Asynchronous level
    output logic dout // Synchronised level
);
    logic stage1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// *** hw/acs_formatter.sv ***
// Turns the accumulated sum into the 16-bit result word.
// Assumes the sum is sign extended for differential mode.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_formatter
    import acs_pkg::*;
(
    input wire logic clk_sys, // Clock for checks only
    input wire logic rst, // Reset for checks only
    input wire acs_acc_t acc, // Accumulated sum
    input wire logic [2:0] sampLog, // Log2 of sample count
    input wire logic res10, // 10-bit resolution
    input wire logic diffMode, // Differential mode
    input wire logic left_adjust_bit, // Left adjust
    output logic [15:0] result // Formatted word
);
    logic [4:0] width;
    logic [4:0] shiftAmt;
    acs_acc_t shifted;

    always_comb begin
        width = (res10 ? `ACS_CODE_W10 : `ACS_CODE_W12) + 5'(sampLog);
        shiftAmt = 5'h00;
        shifted = acc;
        // drop LSbs when over 16 samples and the sum is wider than 16 bits
        if (sampLog > `ACS_FULL_SUM_LOG) begin
            if (width > 5'(`ACS_RES_W)) begin
                shiftAmt = width - 5'(`ACS_RES_W);
            end
            shifted = acc >>> shiftAmt;
        // left adjust fills the low bits with zeros
        end else if (left_adjust_bit) begin
            shiftAmt = 5'(`ACS_RES_W) - width;
            shifted = acc <<< shiftAmt;
        end
        // sign bits come from the extended sum
        result = shifted[15:0];
    end

    property p_se_range;
        @(posedge clk_sys) disable iff (rst)
        (!diffMode && !left_adjust_bit && sampLog == 3'h0)
            |-> result[15:12] == 4'h0 && (!res10 || result[11:10] == 2'h0);
    endproperty
    a_se_range: assert property (p_se_range)
        else $error("single-ended result out of range");

    property p_left_low;
        @(posedge clk_sys) disable iff (rst)
        (left_adjust_bit && !res10 && sampLog == 3'h0) |-> result[3:0] == 4'h0;
    endproperty
    a_left_low: assert property (p_left_low)
        else $error("left adjusted result has low bits set");

    property p_diff_sign;
        @(posedge clk_sys) disable iff (rst)
        (diffMode && !left_adjust_bit && sampLog == 3'h0 && !res10)
            |-> result[15:12] == {4{result[11]}};
    endproperty
    a_diff_sign: assert property (p_diff_sign)
        else $error("differential result not sign extended");
endmodule
`default_nettype wire

// *** tb/acs_core_model.sv ***
// Analog core stand-in: shows a code while converting.
// Assumes the bench sets code and range flags before a start.
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
    input wire logic clk_sys, // System clock
    input wire logic anaConvert, // Conversion active
    input wire logic [11:0] code, // Code to show
    input wire logic hi, // Over range
    input wire logic lo, // Under range
    output logic [11:0] anaData, // Core code
    output logic anaHigh, // Above reference
    output logic anaLow // Below limit
);
    // ====
    // Output window
    logic held = 1'b0;
    always_ff @(posedge clk_sys) begin
        held <= anaConvert;
    end
    assign {anaData, anaHigh, anaLow} = (anaConvert | held) ?
        {code, hi, lo} : ~{code, hi, lo};
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Bench for the sequencer: APB tasks, timing notes, result checks.
// Assumes zero-wait APB and the core model on the analog side.
`timescale 1ns/1ps
`default_nettype none
module tb_top import acs_pkg::*;;
    // ====
    // Signals
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic startEvt = 0, pready, pslverr, er, resultReadyEvt;
    logic anaClkAdc, anaSample, anaConvert, anaHigh, anaLow, hi, lo;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [11:0] anaData, code;
    int n_errors = 0, tests_run = 0, ec = 0, nEvt = 0, tw, tm, tf;
    integer seed = 32'hff3def63;
    int q[$];
    acs_sequencer acs_sequencer_i (.clk_sys(clk_sys), .rst(rst),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .startEvt(startEvt),
        .resultReadyEvt(resultReadyEvt), .anaClkAdc(anaClkAdc),
        .anaSample(anaSample), .anaConvert(anaConvert),
        .anaData(anaData), .anaHigh(anaHigh), .anaLow(anaLow));
    acs_core_model acs_core_model_i (.clk_sys(clk_sys),
        .anaConvert(anaConvert), .code(code), .hi(hi), .lo(lo),
        .anaData(anaData), .anaHigh(anaHigh), .anaLow(anaLow));
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) ec <= ec + 1;
    // ====
    // Checks and monitor
    task automatic chk(input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys) if (resultReadyEvt === 1'b1) begin
        nEvt <= nEvt + 1;
        tm = (q.size() > 0) ? q.pop_front() : -2;
        if (tm != -1) chk(ec, tm);
    end
    // ====
    // Bus and conversion tasks
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        int k;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        k = 0;
        do @(posedge clk_sys) k++; while (pready !== 1'b1 && k < 50);
        rd = prdata; er = pslverr; tw = ec + 1;
        psel <= 0; penable <= 0;
        @(posedge clk_sys);
        if (k >= 50) begin n_errors++; results(); end
    endtask
    task automatic waitEvt(input int n);
        for (int j = 0; j < 20000 && nEvt < n; j++) @(posedge clk_sys);
        if (nEvt < n) begin n_errors++; results(); end
    endtask
    task automatic conv(input logic [4:0] c, logic [2:0] s,
        int p, dl, ln, logic [15:0] e);
        int k;
        apb(1, 8'h00, c); apb(1, 8'h04, s); apb(1, 8'h08, p);
        apb(1, 8'h0C, dl << 8); apb(1, 8'h10, ln);
        k = nEvt;
        apb(1, 8'h14, 1);
        q.push_back(tw + 2 + (1 << s) * ((31 + 2*dl + 2*ln)*(p+1) + 2));
        apb(0, 8'h14, 0); chk(rd[0], 1'b1);
        waitEvt(k + 1);
        apb(0, 8'h20, 0); chk(rd, e);
        apb(0, 8'h14, 0); chk(rd[0], 1'b0);
        apb(0, 8'h1C, 0); chk(rd[0], 1'b1);
        apb(1, 8'h1C, 1);
        hi = 0; lo = 0;
        $display("test done at %0t", $time);
    endtask
    // ====
    // Main sequence
    initial begin
        hi = 0; lo = 0; code = 12'h000;
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        apb(0, 8'h20, 0); chk(rd, 32'h0);
        apb(0, 8'h40, 0); chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        code = $random(seed); conv(5'h01, 0, 0, 0, 0, code);
        code = $random(seed); conv(5'h05, 0, 0, 0, 0, code << 4);
        code = $random(seed); conv(5'h01, 1, 1, 1, 2, code * 2);
        code = $random(seed); conv(5'h11, 0, 0, 0, 0, code >> 2);
        code = $random(seed); conv(5'h01, 5, 0, 0, 0, code * 16);
        hi = 1; conv(5'h01, 0, 0, 0, 0, 16'h0FFF);
        lo = 1; conv(5'h01, 0, 0, 0, 0, 16'h0000);
        code = $random(seed);
        conv(5'h09, 0, 0, 0, 0, {{4{code[11]}}, code});
        hi = 1; conv(5'h09, 0, 0, 0, 0, 16'h07FF);
        lo = 1; conv(5'h09, 0, 0, 0, 0, 16'hF800);
        tf = nEvt; q = '{-1, -1, -1};
        apb(1, 8'h00, 5'h03); apb(1, 8'h04, 1); apb(1, 8'h14, 1);
        waitEvt(tf + 2);
        apb(1, 8'h00, 5'h01); waitEvt(tf + 3);
        apb(0, 8'h20, 0); chk(rd, code * 2);
        results();
    end
endmodule
`default_nettype wire
